// File: verilog/ppf_map.svh
`ifndef PPF_MAP_SVH
`define PPF_MAP_SVH
// Register byte addresses on the AXI4-Lite slave
`define PPF_OFF_CTRL 8'h00
`define PPF_OFF_STATUS 8'h04
`define PPF_OFF_MASK 8'h08
`define PPF_OFF_AUX_OUT 8'h0C
`define PPF_OFF_AUX_IN 8'h10
`define PPF_OFF_DATA 8'h14
`define PPF_OFF_IRQ_REG 8'h18
`define PPF_OFF_SEC_DATA 8'h1C
// Control register fields
`define PPF_CTRL_WIDE 0
`define PPF_CTRL_ENI 2
`define PPF_CTRL_LO_OE 6
`define PPF_CTRL_HI_OE 7
`define PPF_CTRL_LATE 10
// Status register fields
`define PPF_ST_RD_DONE 0
`define PPF_ST_WR_DONE 1
`define PPF_ST_ERR 2
// Host register select codes on the host address lines
`define PPF_HA_DATA_L 3'h0
`define PPF_HA_DATA_H 3'h1
`define PPF_HA_SEC_L 3'h2
`define PPF_HA_SEC_H 3'h3
`define PPF_HA_IRQ_L 3'h4
`define PPF_HA_IRQ_H 3'h5
`define PPF_HA_ERR 3'h6
// Auxiliary sample period in output clock cycles
`define PPF_AUX_PERIOD 4
// Least host idle time in system clock periods
`define PPF_HOST_IDLE_T 2
`define PPF_RESP_OKAY 2'h0
`define PPF_RESP_SLVERR 2'h2
`endif

// File: verilog/ppf_pkg.sv
`default_nettype none
package ppf_pkg;
  typedef enum logic [1:0] {
    PPF_IDLE,
    PPF_READ,
    PPF_WRITE
  } ppf_host_state_t;
  typedef enum logic {
    PPF_SRC_MAILBOX,
    PPF_SRC_ERROR
  } ppf_irq_src_t;
endpackage
`default_nettype wire

// File: verilog/ppf_host_port.sv
// Notes on behaviour
// - Data-full read update: start, or end if late
// - Interrupt-flag read update: start, or end if late
// - Only primary data high/whole read clears data-full
// - Mailbox interrupt cleared reading interrupt register high, or whole when flag enable is set
// - Error interrupt cleared by error status read
// - Only primary data high/whole write sets data-full
// - Flag enable: interrupt register write sets flag
// - Byte mode: upper bus lines become nibbles
// - Aux inputs sampled every four output clocks
// - Aux outputs change at most every four cycles
// - Disable returns lines to input, keeps data
// - Data-full flag on pin and status
//
// The AXI4-Lite register port and the placing of the registers were decided locally.
`include "ppf_map.svh"
`default_nettype none
module ppf_host_port (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Host side
  input wire logic [2:0] host_addr,
  input wire logic host_read_strobe_n,
  input wire logic host_write_strobe_n,
  input wire logic [15:0] parallel_data_bus_in,
  output logic [15:0] parallel_data_bus_out,
  output logic [15:0] parallel_data_bus_oe,
  input wire logic error_event,
  output logic host_data_full_flag,
  output logic host_interrupt_flag,
  output logic irq
);
  // ==========================================================
  // Control state
  logic [15:0] ctrl_q;
  logic [2:0] status_q;
  logic [2:0] mask_q;
  logic [7:0] aux_out_q;
  logic [7:0] aux_drive_q;
  logic [7:0] aux_in_q;
  logic [15:0] data_q;
  logic [15:0] sec_q;
  logic [15:0] irqreg_q;
  logic pdf_q;
  logic pif_q;
  ppf_pkg::ppf_irq_src_t pif_src_q;
  logic [1:0] div_q;
  logic wide;
  logic late;
  assign wide = ctrl_q[`PPF_CTRL_WIDE];
  assign late = ctrl_q[`PPF_CTRL_LATE];

  // ==========================================================
  // Host strobe tracking
  ppf_pkg::ppf_host_state_t hst_q;
  logic [2:0] hadr_q;
  logic rd_start;
  logic rd_end;
  logic wr_end;
  assign rd_start = (hst_q == ppf_pkg::PPF_IDLE) && !host_read_strobe_n;
  assign rd_end = (hst_q == ppf_pkg::PPF_READ) && host_read_strobe_n;
  assign wr_end = (hst_q == ppf_pkg::PPF_WRITE) && host_write_strobe_n;

  // Relies on the host leaving idle time between cycles, so no edge is missed
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hst_q <= ppf_pkg::PPF_IDLE;
      hadr_q <= 3'h0;
    end else if (ce) begin
      case (hst_q)
        ppf_pkg::PPF_IDLE: begin
          if (!host_read_strobe_n) begin
            hst_q <= ppf_pkg::PPF_READ;
            hadr_q <= host_addr;
          end else if (!host_write_strobe_n) begin
            hst_q <= ppf_pkg::PPF_WRITE;
            hadr_q <= host_addr;
          end
        end
        ppf_pkg::PPF_READ: if (host_read_strobe_n) hst_q <= ppf_pkg::PPF_IDLE;
        ppf_pkg::PPF_WRITE: if (host_write_strobe_n) hst_q <= ppf_pkg::PPF_IDLE;
        default: hst_q <= ppf_pkg::PPF_IDLE;
      endcase
    end
  end

  // Which read takes effect this cycle, and with which address
  logic rd_fire;
  logic [2:0] rd_adr;
  assign rd_fire = late ? rd_end : rd_start;
  assign rd_adr = late ? hadr_q : host_addr;

  // In byte mode the high byte access completes a transfer; wide mode uses any half
  function automatic logic hits(input logic [2:0] a, input logic [2:0] hi, input logic w);
    hits = w ? (a[2:1] == hi[2:1]) : (a == hi);
  endfunction

  logic rd_data;
  logic rd_irq;
  logic rd_err;
  logic wr_data;
  logic wr_irq;
  assign rd_data = rd_fire && hits(rd_adr, `PPF_HA_DATA_H, wide);
  assign rd_irq = rd_fire && hits(rd_adr, `PPF_HA_IRQ_H, wide);
  assign rd_err = rd_fire && (rd_adr == `PPF_HA_ERR);
  assign wr_data = wr_end && hits(hadr_q, `PPF_HA_DATA_H, wide);
  assign wr_irq = wr_end && hits(hadr_q, `PPF_HA_IRQ_H, wide);

  // ==========================================================
  // AXI4-Lite slave
  logic aw_ok;
  logic w_ok;
  logic [7:0] awa_q;
  logic aw_have_q;
  logic w_have_q;
  logic [31:0] wd_q;
  logic [3:0] ws_q;
  logic do_wr;
  logic [31:0] wv;
  // Ready drops with the enable, so no beat is taken while state is frozen
  assign s_axi_awready = !aw_have_q && !s_axi_bvalid && ce;
  assign s_axi_wready = !w_have_q && !s_axi_bvalid && ce;
  assign aw_ok = s_axi_awvalid && s_axi_awready;
  assign w_ok = s_axi_wvalid && s_axi_wready;
  assign do_wr = aw_have_q && w_have_q && ce;
  assign wv = wd_q;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awa_q <= 8'h00;
      wd_q <= 32'h0000_0000;
      ws_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PPF_RESP_OKAY;
    end else if (ce) begin
      if (aw_ok) begin
        aw_have_q <= 1'b1;
        awa_q <= s_axi_awaddr;
      end
      if (w_ok) begin
        w_have_q <= 1'b1;
        wd_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awa_q > `PPF_OFF_SEC_DATA || awa_q[1:0] != 2'h0) ?
                       `PPF_RESP_SLVERR : `PPF_RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  logic wr_ctrl;
  logic wr_aux;
  assign wr_ctrl = do_wr && awa_q == `PPF_OFF_CTRL && ws_q[1:0] == 2'h3;
  assign wr_aux = do_wr && awa_q == `PPF_OFF_AUX_OUT && ws_q[0];

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_q <= 16'h0000;
      mask_q <= 3'h0;
      aux_out_q <= 8'h00;
      data_q <= 16'h0000;
      sec_q <= 16'h0000;
      irqreg_q <= 16'h0000;
    end else if (ce) begin
      if (wr_ctrl) ctrl_q <= wv[15:0];
      if (do_wr && awa_q == `PPF_OFF_MASK && ws_q[0]) mask_q <= wv[2:0];
      // Stored contents survive disabling the drive
      if (wr_aux) aux_out_q <= wv[7:0];
      if (do_wr && awa_q == `PPF_OFF_DATA && ws_q[1:0] == 2'h3) data_q <= wv[15:0];
      if (do_wr && awa_q == `PPF_OFF_SEC_DATA && ws_q[1:0] == 2'h3) sec_q <= wv[15:0];
      if (do_wr && awa_q == `PPF_OFF_IRQ_REG && ws_q[1:0] == 2'h3) irqreg_q <= wv[15:0];
      // Host writes land in the data registers, byte by byte or whole
      if (wr_end) begin
        case (hadr_q)
          `PPF_HA_DATA_L: if (wide) data_q <= parallel_data_bus_in;
                          else data_q[7:0] <= parallel_data_bus_in[7:0];
          `PPF_HA_DATA_H: if (wide) data_q <= parallel_data_bus_in;
                          else data_q[15:8] <= parallel_data_bus_in[7:0];
          `PPF_HA_SEC_L: if (wide) sec_q <= parallel_data_bus_in;
                         else sec_q[7:0] <= parallel_data_bus_in[7:0];
          `PPF_HA_SEC_H: if (wide) sec_q <= parallel_data_bus_in;
                         else sec_q[15:8] <= parallel_data_bus_in[7:0];
          default: ;
        endcase
      end
    end
  end

  // ==========================================================
  // Data-full and host interrupt flags
  logic pif_set_mbx;
  assign pif_set_mbx = (do_wr && awa_q == `PPF_OFF_IRQ_REG) ||
                       (wr_irq && ctrl_q[`PPF_CTRL_ENI]);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pdf_q <= 1'b0;
    end else if (ce) begin
      // Set wins over clear when both land in one cycle
      if (wr_data || (do_wr && awa_q == `PPF_OFF_DATA)) begin
        pdf_q <= 1'b1;
      end else if (rd_data) begin
        pdf_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pif_q <= 1'b0;
      pif_src_q <= ppf_pkg::PPF_SRC_MAILBOX;
    end else if (ce) begin
      if (pif_set_mbx) begin
        pif_q <= 1'b1;
        pif_src_q <= ppf_pkg::PPF_SRC_MAILBOX;
      end else if (error_event && mask_q[`PPF_ST_ERR]) begin
        pif_q <= 1'b1;
        pif_src_q <= ppf_pkg::PPF_SRC_ERROR;
      end else if (pif_src_q == ppf_pkg::PPF_SRC_MAILBOX && rd_irq &&
                   (!wide || ctrl_q[`PPF_CTRL_ENI])) begin
        pif_q <= 1'b0;
      end else if (pif_src_q == ppf_pkg::PPF_SRC_ERROR && rd_err) begin
        pif_q <= 1'b0;
      end
    end
  end
  assign host_data_full_flag = pdf_q;
  assign host_interrupt_flag = pif_q;

  // ==========================================================
  // Interrupt status, write one to clear
  logic [2:0] ev;
  assign ev = {error_event, wr_end, rd_fire};
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      status_q <= 3'h0;
    end else if (ce) begin
      if (do_wr && awa_q == `PPF_OFF_STATUS && ws_q[0]) begin
        status_q <= (status_q & ~wv[2:0]) | ev;
      end else begin
        status_q <= status_q | ev;
      end
    end
  end
  assign irq = |(status_q & mask_q);

  // ==========================================================
  // Auxiliary nibble ports, paced by a divide-by-four output clock
  // Slow sensing only: inputs are not filtered beyond the four-cycle sample
  logic tick;
  assign tick = (div_q == 2'(`PPF_AUX_PERIOD - 1));
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      div_q <= 2'h0;
      aux_in_q <= 8'h00;
      aux_drive_q <= 8'h00;
    end else if (ce) begin
      div_q <= div_q + 2'h1;
      if (tick) begin
        aux_in_q <= parallel_data_bus_in[15:8];
        aux_drive_q <= aux_out_q;
      end
    end
  end

  logic aux_mode;
  logic [7:0] aux_oe;
  assign aux_mode = !wide;
  assign aux_oe = {{4{aux_mode && ctrl_q[`PPF_CTRL_HI_OE]}},
                   {4{aux_mode && ctrl_q[`PPF_CTRL_LO_OE]}}};

  // ==========================================================
  // Host read data on the bus
  logic [15:0] hrd;
  always_comb begin
    case (host_addr)
      `PPF_HA_DATA_L: hrd = wide ? data_q : {8'h00, data_q[7:0]};
      `PPF_HA_DATA_H: hrd = wide ? data_q : {8'h00, data_q[15:8]};
      `PPF_HA_SEC_L: hrd = wide ? sec_q : {8'h00, sec_q[7:0]};
      `PPF_HA_SEC_H: hrd = wide ? sec_q : {8'h00, sec_q[15:8]};
      `PPF_HA_IRQ_L: hrd = wide ? irqreg_q : {8'h00, irqreg_q[7:0]};
      `PPF_HA_IRQ_H: hrd = wide ? irqreg_q : {8'h00, irqreg_q[15:8]};
      default: hrd = {13'h0000, status_q};
    endcase
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      parallel_data_bus_out <= 16'h0000;
    end else if (ce) begin
      parallel_data_bus_out <= {aux_mode ? aux_drive_q : hrd[15:8], hrd[7:0]};
    end
  end
  assign parallel_data_bus_oe = {aux_mode ? aux_oe : {8{!host_read_strobe_n}},
                                 {8{!host_read_strobe_n}}};

  // ==========================================================
  // AXI read channel
  assign s_axi_arready = !s_axi_rvalid && ce;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `PPF_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `PPF_RESP_OKAY;
        case (s_axi_araddr)
          `PPF_OFF_CTRL: s_axi_rdata <= {16'h0000, ctrl_q};
          `PPF_OFF_STATUS: s_axi_rdata <= {27'h0, pif_q, pdf_q, status_q};
          `PPF_OFF_MASK: s_axi_rdata <= {29'h0, mask_q};
          `PPF_OFF_AUX_OUT: s_axi_rdata <= {24'h0, aux_out_q};
          `PPF_OFF_AUX_IN: s_axi_rdata <= {24'h0, aux_in_q};
          `PPF_OFF_DATA: s_axi_rdata <= {16'h0000, data_q};
          `PPF_OFF_IRQ_REG: s_axi_rdata <= {16'h0000, irqreg_q};
          `PPF_OFF_SEC_DATA: s_axi_rdata <= {16'h0000, sec_q};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `PPF_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// File: testbench/ppf_host_port_checker.sv
`default_nettype none
module ppf_host_port_checker (
  input wire logic mclk,
  input wire logic rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic host_read_strobe_n,
  input wire logic host_write_strobe_n,
  input wire logic [15:0] parallel_data_bus_out,
  input wire logic [15:0] parallel_data_bus_oe,
  input wire logic error_event,
  input wire logic host_data_full_flag,
  input wire logic host_interrupt_flag
);
  // ========================================
  // Flag and bus timing
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // A read fires on its start edge or, with late timing, on its end edge
  sequence host_read_fired;
    !$past(host_read_strobe_n) || !$past(host_read_strobe_n, 2);
  endsequence
  sequence axi_wr_seen;
    $past(s_axi_wvalid) || $past(s_axi_wvalid, 2) || $past(s_axi_wvalid, 3);
  endsequence
  sequence aw_w_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  a_full_fall_cause: assert property ($fell(host_data_full_flag) |-> host_read_fired)
    else $error("data full flag fell without a host read");
  a_intr_fall_cause: assert property ($fell(host_interrupt_flag) |-> host_read_fired)
    else $error("interrupt flag fell without a host read");
  a_full_rise_cause: assert property ($rose(host_data_full_flag) |->
    axi_wr_seen or !$past(host_write_strobe_n, 2))
    else $error("data full flag rose without a write");
  a_intr_rise_cause: assert property ($rose(host_interrupt_flag) |->
    axi_wr_seen or !$past(host_write_strobe_n, 2) or $past(error_event) or $past(error_event, 2))
    else $error("interrupt flag rose without a cause");
  a_aux_oe_nibble: assert property (parallel_data_bus_oe[11:8] inside {4'h0, 4'hF} &&
    parallel_data_bus_oe[15:12] inside {4'h0, 4'hF})
    else $error("aux nibble enables split");
  a_aux_oe_cause: assert property ($changed(parallel_data_bus_oe[15:8]) &&
    host_read_strobe_n && $past(host_read_strobe_n) |-> s_axi_bvalid)
    else $error("aux drive enables changed without a control write");
  a_aux_out_pace: assert property ($changed(parallel_data_bus_out[15:8]) &&
    parallel_data_bus_oe == 16'hFF00 |=> $stable(parallel_data_bus_out[15:8])[*3])
    else $error("aux output changed within four cycles");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_wr_answer: assert property (aw_w_taken |-> ##[1:3] s_axi_bvalid)
    else $error("write answer late");
endmodule
bind ppf_host_port ppf_host_port_checker u_chk (
  .mclk(mclk),
  .rst(rst),
  .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid),
  .host_read_strobe_n(host_read_strobe_n),
  .host_write_strobe_n(host_write_strobe_n),
  .parallel_data_bus_out(parallel_data_bus_out),
  .parallel_data_bus_oe(parallel_data_bus_oe),
  .error_event(error_event),
  .host_data_full_flag(host_data_full_flag),
  .host_interrupt_flag(host_interrupt_flag)
);
`default_nettype wire

// File: testbench/ppf_host_model.sv
`default_nettype none
module ppf_host_model (
  input wire logic mclk,
  input wire logic [7:0] aux_drive,
  output logic [2:0] host_addr,
  output logic host_read_strobe_n,
  output logic host_write_strobe_n,
  output logic [15:0] parallel_data_bus_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] low_q = 8'h00;
  initial begin
    host_addr = 3'h0;
    host_read_strobe_n = 1'b1;
    host_write_strobe_n = 1'b1;
  end
  assign parallel_data_bus_in = {aux_drive, low_q};
  // ========================================
  // One host cycle: 2T strobe, data held past the end edge
  task automatic xfer(input logic wr, input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    host_addr <= a;
    low_q <= wr ? d : ~low_q;
    host_read_strobe_n <= wr;
    host_write_strobe_n <= !wr;
    repeat (2) @(posedge mclk);
    host_read_strobe_n <= 1'b1;
    host_write_strobe_n <= 1'b1;
    @(posedge mclk);
    // Released lines show a changed value, not the stale one
    low_q <= ~low_q;
    @(posedge mclk);
  endtask
endmodule
`default_nettype wire

// File: testbench/tb.sv
`include "ppf_map.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0, rst = 1'b1, error_event = 1'b0, ce = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, aux_drive = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic host_read_strobe_n, host_write_strobe_n, host_data_full_flag, host_interrupt_flag;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [2:0] host_addr;
  logic [15:0] parallel_data_bus_in, parallel_data_bus_out, parallel_data_bus_oe;
  int failures = 0, checks_done = 0;
  logic [7:0] row_a [4] = '{`PPF_OFF_CTRL, `PPF_OFF_MASK, `PPF_OFF_AUX_OUT, 8'h40};
  logic [31:0] row_d [4] = '{32'h485, 32'h7, 32'hA5, 32'h1};
  logic [1:0] row_r [4] = '{`PPF_RESP_OKAY, `PPF_RESP_OKAY, `PPF_RESP_OKAY, `PPF_RESP_SLVERR};
  logic [31:0] q;
  logic [1:0] r;
  ppf_host_port dut (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .host_addr(host_addr),
    .host_read_strobe_n(host_read_strobe_n),
    .host_write_strobe_n(host_write_strobe_n),
    .parallel_data_bus_in(parallel_data_bus_in),
    .parallel_data_bus_out(parallel_data_bus_out),
    .parallel_data_bus_oe(parallel_data_bus_oe),
    .error_event(error_event),
    .host_data_full_flag(host_data_full_flag),
    .host_interrupt_flag(host_interrupt_flag),
    .irq(irq)
  );
  ppf_host_model u_host (
    .mclk(mclk),
    .aux_drive(aux_drive),
    .host_addr(host_addr),
    .host_read_strobe_n(host_read_strobe_n),
    .host_write_strobe_n(host_write_strobe_n),
    .parallel_data_bus_in(parallel_data_bus_in)
  );
  initial begin
    forever #5 mclk = ~mclk;
  end
  // ========================================
  // Bus and compare tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid && !s_axi_awready || s_axi_wvalid && !s_axi_wready);
    while (!s_axi_bvalid) @(posedge mclk);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    @(posedge mclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do @(posedge mclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge mclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic w(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] rs;
    axi_wr(a, d, rs);
    @(posedge mclk);
    #1;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] rs;
    axi_rd(a, d, rs);
    chk(d & m, e);
  endtask
  // Host cycle; flag f checked mid-strobe (m) and after the cycle (e)
  task automatic hx(input logic wr, input logic [2:0] a, input logic [7:0] d,
                    input logic m, input logic e, input logic f);
    fork
      u_host.xfer(wr, a, d);
      begin
        repeat (3) @(posedge mclk);
        #1;
        chk(32'(f ? host_interrupt_flag : host_data_full_flag), 32'(m));
      end
    join
    @(posedge mclk);
    #1;
    chk(32'(f ? host_interrupt_flag : host_data_full_flag), 32'(e));
  endtask
  task automatic err_pulse;
    @(posedge mclk) error_event <= 1'b1;
    @(posedge mclk) error_event <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
  endtask
  task automatic test_done;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge mclk);
    failures++;
    test_done;
  end
  // ========================================
  // Main sequence
  initial begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      axi_wr(row_a[i], row_d[i], r);
      chk(32'(r), 32'(row_r[i]));
      axi_rd(row_a[i], q, r);
      chk(32'(r), 32'(row_r[i]));
      if (row_r[i] == `PPF_RESP_OKAY) chk(q, row_d[i]);
    end
    @(posedge mclk) rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    #1;
    chk(32'({parallel_data_bus_oe, host_data_full_flag, host_interrupt_flag, irq}), 32'h0);
    rchk(`PPF_OFF_CTRL, 32'hFFFFFFFF, 32'h0);
    w(`PPF_OFF_DATA, 32'h1234);
    rchk(`PPF_OFF_STATUS, 32'h8, 32'h8);
    hx(1'b0, `PPF_HA_DATA_L, 8'h00, 1'b1, 1'b1, 1'b0);
    hx(1'b0, `PPF_HA_SEC_H, 8'h00, 1'b1, 1'b1, 1'b0);
    hx(1'b0, `PPF_HA_DATA_H, 8'h00, 1'b0, 1'b0, 1'b0);
    chk(32'(parallel_data_bus_out[7:0]), 32'h12);
    hx(1'b1, `PPF_HA_DATA_L, 8'h11, 1'b0, 1'b0, 1'b0);
    hx(1'b1, `PPF_HA_SEC_H, 8'h22, 1'b0, 1'b0, 1'b0);
    hx(1'b1, `PPF_HA_DATA_H, 8'h33, 1'b0, 1'b1, 1'b0);
    chk(32'(parallel_data_bus_out[7:0]), 32'h33);
    w(`PPF_OFF_CTRL, 32'h1 << `PPF_CTRL_LATE);
    hx(1'b0, `PPF_HA_DATA_H, 8'h00, 1'b1, 1'b0, 1'b0);
    w(`PPF_OFF_IRQ_REG, 32'h5);
    hx(1'b0, `PPF_HA_IRQ_L, 8'h00, 1'b1, 1'b1, 1'b1);
    hx(1'b0, `PPF_HA_IRQ_H, 8'h00, 1'b1, 1'b0, 1'b1);
    w(`PPF_OFF_CTRL, 32'h1 << `PPF_CTRL_ENI);
    hx(1'b1, `PPF_HA_IRQ_H, 8'h5A, 1'b0, 1'b1, 1'b1);
    hx(1'b0, `PPF_HA_IRQ_H, 8'h00, 1'b0, 1'b0, 1'b1);
    w(`PPF_OFF_STATUS, 32'h7);
    w(`PPF_OFF_MASK, 32'h4);
    err_pulse;
    chk(32'({host_interrupt_flag, irq}), 32'h3);
    hx(1'b0, `PPF_HA_ERR, 8'h00, 1'b0, 1'b0, 1'b1);
    w(`PPF_OFF_STATUS, 32'h4);
    chk(32'(irq), 32'h0);
    w(`PPF_OFF_MASK, 32'h0);
    err_pulse;
    chk(32'({host_interrupt_flag, irq}), 32'h0);
    rchk(`PPF_OFF_STATUS, 32'h4, 32'h4);
    // A single-byte strobe must not land in a 16-bit register
    @(posedge mclk) s_axi_wstrb <= 4'h1;
    w(`PPF_OFF_CTRL, 32'h1);
    rchk(`PPF_OFF_CTRL, 32'hFFFF, 32'h4);
    @(posedge mclk) s_axi_wstrb <= 4'hF;
    // Wide port: either half of a register counts as the whole
    w(`PPF_OFF_CTRL, 32'h1);
    hx(1'b1, `PPF_HA_DATA_L, 8'h66, 1'b0, 1'b1, 1'b0);
    hx(1'b0, `PPF_HA_SEC_L, 8'h00, 1'b1, 1'b1, 1'b0);
    hx(1'b0, `PPF_HA_DATA_L, 8'h00, 1'b0, 1'b0, 1'b0);
    chk(32'(parallel_data_bus_out), 32'h0066);
    w(`PPF_OFF_IRQ_REG, 32'h5);
    hx(1'b0, `PPF_HA_IRQ_H, 8'h00, 1'b1, 1'b1, 1'b1);
    w(`PPF_OFF_CTRL, 32'h5);
    hx(1'b0, `PPF_HA_IRQ_L, 8'h00, 1'b0, 1'b0, 1'b1);
    w(`PPF_OFF_CTRL, 32'hC0);
    w(`PPF_OFF_AUX_OUT, 32'h3C);
    repeat (8) @(posedge mclk);
    #1;
    chk(32'({parallel_data_bus_oe[15:8], parallel_data_bus_out[15:8]}), 32'hFF3C);
    w(`PPF_OFF_CTRL, 32'h80);
    chk(32'(parallel_data_bus_oe[11:8]), 32'h0);
    rchk(`PPF_OFF_AUX_OUT, 32'hFF, 32'h3C);
    w(`PPF_OFF_CTRL, 32'h0);
    @(posedge mclk) aux_drive <= 8'h5A;
    repeat (8) @(posedge mclk);
    rchk(`PPF_OFF_AUX_IN, 32'hFF, 32'h5A);
    // With the enable low a full data write must leave the flag alone
    @(posedge mclk) ce <= 1'b0;
    hx(1'b1, `PPF_HA_DATA_H, 8'h77, 1'b0, 1'b0, 1'b0);
    @(posedge mclk) ce <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    chk(32'(host_data_full_flag), 32'h0);
    test_done;
  end
endmodule
`default_nettype wire
